// [core/mdt_ms_timer.sv]
// Millisecond interval timer used for tenure and reply timing.
// Assumes tick is a one-cycle pulse once per millisecond on sys_clk.
`timescale 1ns/1ps
module mdt_ms_timer
  import mdt_pkg::*;
(
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Control.
  input  wire logic             restart,
  input  wire logic             tick,
  input  wire logic [TMR_W-1:0] limit,
  // Status.
  output logic                  expired,
  output logic [TMR_W-1:0]      elapsed
);

  logic [TMR_W-1:0] cnt_q;
  logic             exp_q;
  logic             at_limit;

  // The expiry is sticky until restart so a late reader cannot miss it.
  assign at_limit = tick && (cnt_q >= limit - TMR_W'(1));
  assign expired  = exp_q;
  assign elapsed  = cnt_q;

  // Count ticks; restart wins over a tick in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end
    else if (restart)
    begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end
    else if (tick && !exp_q)
    begin
      cnt_q <= cnt_q + TMR_W'(1);
      exp_q <= at_limit;
    end
  end

endmodule

// [core/mdt_pkg.sv]
// Shared constants and types for the multidrop access-right token controller.
// Assumes a message framer outside that builds and checks the serial frames.
package mdt_pkg;

  // Station numbers on the shared link.
  localparam logic [7:0]  STN_FIRST     = 8'h80;
  localparam logic [7:0]  STN_LAST      = 8'h9f;
  localparam logic [7:0]  STN_BCAST     = 8'ha0;

  // Inter-computer commands, two ASCII characters each.
  localparam logic [15:0] CMD_PASS      = 16'h5a54;
  localparam logic [15:0] CMD_REPLY     = 16'h5a52;
  localparam logic [15:0] CMD_TAKEOVER  = 16'h5a5a;

  // Timing, with the clock rate and the millisecond figures.
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          MS_CYCLES     = CLK_HZ / 1000;
  localparam int          MAX_TIME_MS   = 100;
  localparam int          REPLY_TIME_MS = 10;
  localparam int          GUARD_MS      = 5;
  localparam int          TMR_W         = 16;
  localparam logic [TMR_W-1:0] MAX_TICKS   = TMR_W'(MAX_TIME_MS);
  localparam logic [TMR_W-1:0] REPLY_TICKS = TMR_W'(REPLY_TIME_MS);
  localparam logic [TMR_W-1:0] GUARD_TICKS = TMR_W'(MAX_TIME_MS - GUARD_MS);

  // Cycles the station strap needs to pass its synchroniser.
  localparam logic [1:0]  SYNC_WAIT     = 2'h3;

  // One inter-computer message as handed to or from the framer.
  typedef struct packed {
    logic [7:0]  dst;
    logic [7:0]  src;
    logic [15:0] cmd;
  } mdt_msg_t;

  // Controller states.
  typedef enum logic [6:0] {
    ST_START = 7'h01,
    ST_MON   = 7'h02,
    ST_HOLD  = 7'h04,
    ST_PASS  = 7'h08,
    ST_WAITR = 7'h10,
    ST_REPLY = 7'h20,
    ST_TAKE  = 7'h40
  } mdt_state_t;

endpackage

// [core/mdt_token_host.sv]
// Host-side access-right token controller for an m:n multidrop link.
// Assumes a framer on the same clock that sends tx_msg on tx_valid/tx_ready and
// presents each received, sum-checked inter-computer message as a one-cycle rx_valid.
//
// Function
// RL1: Each host computer uses its own station number from 80H to 9FH.
// RL2: Station A0H addresses every host computer at once as broadcast.
// RL3: Holder finishes all exchanges before the maximum communications time elapses.
// RL4: Late holder sends clear code in time and reinitialises its link sequence.
// RL5: Non-holders run the time-out check and withhold their own transmissions.
// RL6: Inter-computer commands avoid codes of the module's dedicated protocol.
// RL7: Module answers NAK to computer messages addressed to stations 00H-31H.
// RL8: In modes A, B, D the module talks only to main-channel computer.
// RL9: At start the computer with station 80H takes the access right.
// RL10: Holder with no work passes the right at once, else after finishing.
// RL11: Non-holders time the tenure and discard data addressed to other stations.
// RL12: Release by sending a transfer message to the next station number.
// RL13: Without a reply, try each following station in order until acknowledged.
// RL14: Receiver of the right replies to the giver, then acts as holder.
// RL15: On holder timeout the next station broadcasts a takeover and holds.
// RL16: If no takeover broadcast arrives, the following station issues its own.
// RL17: Module ignores received data addressed to another station.
// RL18: Full-duplex only; at most 32 computers and 32 modules.
// RL19: Restart tenure timing on each observed transfer or takeover broadcast; the code restarts on each observed reply, not on a transfer.
`timescale 1ns/1ps
module mdt_token_host
  import mdt_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
)
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Station strap.
  input  wire logic [7:0] my_station,
  // Local user.
  input  wire logic       work_pending,
  input  wire logic       work_done,
  output logic            holds_right,
  output logic            clear_req,
  // Framer transmit side.
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output mdt_msg_t        tx_msg,
  // Framer receive side.
  input  wire logic       rx_valid,
  input  wire mdt_msg_t   rx_msg
);

  mdt_state_t       state_q, state_d;
  logic [7:0]       stn_s1_q, stn_s2_q, my_q;
  logic [1:0]       start_cnt_q;
  logic [7:0]       holder_q, holder_d, target_q, target_d, giver_q, giver_d;
  logic [31:0]      ms_cnt_q;
  logic             tick_q;
  logic             tx_valid_q, holds_q, clear_q;
  mdt_msg_t         tx_msg_q, tx_msg_d;
  logic             tenure_exp, reply_exp, tenure_restart, reply_restart;
  logic [TMR_W-1:0] tenure_el;

  // Successor on the ring of station numbers, used in several places.
  function automatic logic [7:0] next_stn(input logic [7:0] s);
    next_stn = (s == STN_LAST) ? STN_FIRST : 8'(s + 8'h01);                   // [RL18]
  endfunction

  // Receive decode; of frames to other stations only a reply acts, restarting tenure timing and naming the holder.
  wire start_go   = (state_q == ST_START) && (start_cnt_q == SYNC_WAIT);
  wire rx_for_me  = rx_valid && (rx_msg.dst == my_q);                          // [RL11]
  wire rx_bcast   = rx_valid && (rx_msg.dst == STN_BCAST);                     // [RL2]
  wire rx_pass_me = rx_for_me && (rx_msg.cmd == CMD_PASS);
  wire rx_reply   = rx_valid && (rx_msg.cmd == CMD_REPLY);
  wire rx_ack_me  = rx_for_me && (rx_msg.cmd == CMD_REPLY) && (rx_msg.src == target_q);
  wire rx_take    = rx_bcast && (rx_msg.cmd == CMD_TAKEOVER);
  wire tx_fire    = tx_valid_q && tx_ready;
  wire done_work  = !work_pending || work_done;                                // [RL10]
  wire late       = tenure_el >= GUARD_TICKS;                                  // [RL3]
  wire succ_is_me = next_stn(holder_q) == my_q;
  wire retry_me   = next_stn(target_q) == my_q;
  wire hold_entry = (state_d == ST_HOLD) && (state_q != ST_HOLD);

  // A reply or takeover seen anywhere on the line restarts tenure timing.
  assign tenure_restart = start_go || rx_reply || rx_take || hold_entry        // [RL19]
                          || ((state_q == ST_MON) && tenure_exp);
  assign reply_restart  = tx_fire && (state_q == ST_PASS);

  // Strap synchroniser; the first stage feeds only the second.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stn_s1_q <= 8'h00;
      stn_s2_q <= 8'h00;
    end
    else
    begin
      stn_s1_q <= my_station;
      stn_s2_q <= stn_s1_q;
    end
  end

  // Millisecond enable; the divider is a parameter so simulation can shorten it.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ms_cnt_q <= 32'h0;
      tick_q   <= 1'b0;
    end
    else
    begin
      tick_q   <= (ms_cnt_q == 32'(MS_CYC - 1));
      ms_cnt_q <= (ms_cnt_q == 32'(MS_CYC - 1)) ? 32'h0 : ms_cnt_q + 32'h1;
    end
  end

  // Tenure timer serves both our own hold and watching another holder.
  mdt_ms_timer u_tenure (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .restart (tenure_restart),
    .tick    (tick_q),
    .limit   (MAX_TICKS),
    .expired (tenure_exp),
    .elapsed (tenure_el)
  );

  // Reply timer bounds the wait for a successor's acknowledgement.
  mdt_ms_timer u_reply (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .restart (reply_restart),
    .tick    (tick_q),
    .limit   (REPLY_TICKS),
    .expired (reply_exp),
    .elapsed ()
  );

  // Next-state logic. Only the holder ever sends a transfer; in monitor we stay silent.
  always_comb
  begin
    state_d  = state_q;
    holder_d = holder_q;
    target_d = target_q;
    giver_d  = giver_q;
    unique case (state_q)
      ST_START:
        if (start_go)
        begin
          holder_d = STN_FIRST;
          state_d  = (stn_s2_q == STN_FIRST) ? ST_HOLD : ST_MON;               // [RL9]
        end
      ST_MON:                                                                  // [RL5]
        if (rx_pass_me)
        begin
          giver_d = rx_msg.src;
          state_d = ST_REPLY;                                                  // [RL14]
        end
        else if (rx_take || rx_reply)
          holder_d = rx_msg.src;
        else if (tenure_exp)
        begin
          if (succ_is_me)
            state_d = ST_TAKE;                                                 // [RL15]
          else
            holder_d = next_stn(holder_q);                                     // [RL16]
        end
      ST_HOLD:
        if (done_work || late)
        begin
          target_d = next_stn(my_q);                                           // [RL12]
          state_d  = (next_stn(my_q) == my_q) ? ST_HOLD : ST_PASS;
        end
      ST_PASS:
        if (tx_fire)
          state_d = ST_WAITR;
      ST_WAITR:
        if (rx_ack_me)
        begin
          holder_d = target_q;
          state_d  = ST_MON;
        end
        else if (reply_exp)
        begin
          target_d = next_stn(target_q);                                       // [RL13]
          state_d  = retry_me ? ST_HOLD : ST_PASS;
        end
      ST_REPLY:
        if (tx_fire)
          state_d = ST_HOLD;
      ST_TAKE:
        if (tx_fire)
          state_d = ST_HOLD;
      default:
        state_d = ST_START;
    endcase
  end

  // Outgoing message and its request follow the state it is sent from.
  assign tx_msg_d = (state_d == ST_REPLY) ? mdt_msg_t'{dst: giver_d, src: my_q, cmd: CMD_REPLY}
                  : (state_d == ST_TAKE)  ? mdt_msg_t'{dst: STN_BCAST, src: my_q, cmd: CMD_TAKEOVER}
                  : mdt_msg_t'{dst: target_d, src: my_q, cmd: CMD_PASS};       // [RL6]
  wire send_d = (state_d == ST_PASS) || (state_d == ST_REPLY) || (state_d == ST_TAKE);

  // State and token bookkeeping.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q     <= ST_START;
      start_cnt_q <= 2'h0;
      my_q        <= STN_FIRST;
      holder_q    <= STN_FIRST;
      target_q    <= STN_FIRST;
      giver_q     <= STN_FIRST;
    end
    else
    begin
      state_q     <= state_d;
      start_cnt_q <= (start_cnt_q == SYNC_WAIT) ? start_cnt_q : start_cnt_q + 2'h1;
      my_q        <= start_go ? stn_s2_q : my_q;
      holder_q    <= holder_d;
      target_q    <= target_d;
      giver_q     <= giver_d;
    end
  end

  // Registered outputs. A late holder asks the framer for the clear code and a resync.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_valid_q <= 1'b0;
      tx_msg_q   <= '0;
      holds_q    <= 1'b0;
      clear_q    <= 1'b0;
    end
    else
    begin
      tx_valid_q <= send_d && !(tx_fire && state_d == state_q);
      tx_msg_q   <= tx_msg_d;
      holds_q    <= state_d == ST_HOLD;
      clear_q    <= (state_q == ST_HOLD) && late && !done_work;                 // [RL4]
    end
  end

  assign tx_valid    = tx_valid_q;
  assign tx_msg      = tx_msg_q;
  assign holds_right = holds_q;
  assign clear_req   = clear_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_late_hold;
    (state_q == ST_HOLD) && late && !done_work;
  endsequence
  sequence s_clear_pass;
    clear_req && (state_q == ST_PASS);
  endsequence

  property p_bcast_dst;
    tx_valid && (tx_msg.cmd == CMD_TAKEOVER) |-> tx_msg.dst == STN_BCAST;
  endproperty
  a_bcast_dst: assert property (p_bcast_dst) else $error("Takeover not broadcast."); // [RL2]
  property p_dst_range;
    tx_valid && (tx_msg.cmd != CMD_TAKEOVER) |-> (tx_msg.dst >= STN_FIRST) && (tx_msg.dst <= STN_LAST);
  endproperty
  a_dst_range: assert property (p_dst_range) else $error("Destination out of range."); // [RL1]
  property p_late_clear;
    s_late_hold |=> s_clear_pass;
  endproperty
  a_late_clear: assert property (p_late_clear) else $error("Late holder did not clear."); // [RL4]
  property p_mon_quiet;
    (state_q == ST_MON) && $past(state_q == ST_MON) |-> !tx_valid;
  endproperty
  a_mon_quiet: assert property (p_mon_quiet) else $error("Non-holder transmitted."); // [RL5]
  property p_start_low;
    start_go && (stn_s2_q == STN_FIRST) |=> holds_right && (state_q == ST_HOLD);
  endproperty
  a_start_low: assert property (p_start_low) else $error("Station 80H did not hold."); // [RL9]
  property p_idle_pass;
    (state_q == ST_HOLD) && !work_pending && (next_stn(my_q) != my_q) |=> (state_q == ST_PASS) && tx_valid
      && (tx_msg.dst == next_stn(my_q)) && !holds_right;
  endproperty
  a_idle_pass: assert property (p_idle_pass) else $error("Idle holder kept right."); // [RL10]
  property p_retry;
    (state_q == ST_WAITR) && !rx_ack_me && reply_exp && !retry_me |=> (state_q == ST_PASS)
      && (target_q == next_stn($past(target_q)));
  endproperty
  a_retry: assert property (p_retry) else $error("No retry to following station."); // [RL13]
  property p_takeover;
    (state_q == ST_MON) && !rx_pass_me && !rx_take && !rx_reply && tenure_exp && succ_is_me
      |=> tx_valid && (tx_msg.cmd == CMD_TAKEOVER) ##[1:1000] holds_right;
  endproperty
  a_takeover: assert property (p_takeover) else $error("Takeover not issued."); // [RL15]

endmodule

// [dv/mdt_peer_model.sv]
// Far-side model: the other host computers on the link, seen through the framer.
// Assumes the controller's framer ports on sys_clk; the bench may inject frames with send.
`timescale 1ns/1ps
module mdt_peer_model
  import mdt_pkg::*;
(
  // Clock.
  input  wire logic        sys_clk,
  // Framer transmit side.
  input  wire logic        tx_valid,
  input  wire mdt_msg_t    tx_msg,
  output logic             tx_ready,
  // Framer receive side.
  output logic             rx_valid,
  output mdt_msg_t         rx_msg,
  // Behaviour: mute stations, stall the framer.
  input  wire logic [31:0] silent,
  input  wire logic        slow
);
  mdt_msg_t last_msg;
  int       taken;
  int       faulty;

  // Quiet start, nothing offered to the controller.
  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_msg   = '0;
    taken    = 0;
    faulty   = 0;
  end

  // One checked frame; afterwards the line shows the inverse, never a stale copy.
  task automatic send(input mdt_msg_t m);
    @(negedge sys_clk);
    rx_msg   = m;
    rx_valid = 1'b1;  // Every frame arrives on the main channel.
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_msg   = ~m;
  endtask

  // Slow mode stalls every other cycle so that held requests get exercised.
  always @(negedge sys_clk)
    tx_ready <= slow ? ~tx_ready : 1'b1;

  // A live station answers a transfer addressed to it; broadcasts get no answer.
  always
  begin
    @(posedge sys_clk);
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      last_msg = tx_msg;
      taken    = taken + 1;
      if (tx_msg.dst <= 8'h31)
        faulty = faulty + 1;  // A module would take this as faulty and answer NAK.
      if (tx_msg.cmd == CMD_PASS && tx_msg.dst != STN_BCAST && !silent[tx_msg.dst[4:0]])
      begin
        repeat (3) @(negedge sys_clk);
        send({tx_msg.src, tx_msg.dst, CMD_REPLY});
      end
    end
  end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the access-right token controller.
// Assumes the design package and the far-side model; ticks are shortened to four cycles.
`timescale 1ns/1ps
module testbench
  import mdt_pkg::*;
;
  localparam int MSC = 4;
  logic          sys_clk      = 1'b0;
  logic          rst_b        = 1'b0;
  logic [7:0]    my_station   = 8'h80;
  logic          work_pending = 1'b0;
  logic          work_done    = 1'b0;
  logic [31:0]   silent       = '0;
  logic          slow         = 1'b0;
  logic          holds_right, clear_req, tx_valid, tx_ready, rx_valid;
  mdt_msg_t      tx_msg, rx_msg, got;
  int            fails = 0, samples_checked = 0, cyc = 0, clears = 0, clear_at = 0, hold_at = 0;

  always #20 sys_clk = ~sys_clk;

  mdt_peer_model peer (.sys_clk(sys_clk), .tx_valid(tx_valid), .tx_msg(tx_msg), .tx_ready(tx_ready),
                       .rx_valid(rx_valid), .rx_msg(rx_msg), .silent(silent), .slow(slow));

  mdt_token_host #(.MS_CYC(MSC)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .my_station(my_station),
    .work_pending(work_pending), .work_done(work_done), .holds_right(holds_right),
    .clear_req(clear_req), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_msg(tx_msg),
    .rx_valid(rx_valid), .rx_msg(rx_msg));

  // Time stamps of tenure start and clear pulses, for the guard-time check.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if ($rose(holds_right))
      hold_at <= cyc;
    if (clear_req === 1'b1)
    begin
      clears   <= clears + 1;
      clear_at <= cyc;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // The strap is latched only after reset, so each scenario starts from reset.
  task automatic do_reset(input logic [7:0] stn, input logic pend, input logic [31:0] mute, input logic stall);
    @(negedge sys_clk);
    rst_b        = 1'b0;
    my_station   = stn;
    work_pending = pend;
    silent       = mute;
    slow         = stall;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
  endtask

  // Waits for the next frame the framer takes, giving up after limit cycles.
  task automatic wait_tx(input int limit);
    int n0;
    n0 = peer.taken;
    for (int i = 0; i < limit && peer.taken == n0; i++)
      @(negedge sys_clk);
    check("frame_taken", peer.taken != n0, 1'b1);
    got = peer.last_msg;
  endtask

  // No frame may be taken during n cycles.
  task automatic quiet(input int n);
    int n0;
    n0 = peer.taken;
    repeat (n) @(negedge sys_clk);
    check("no_frame", peer.taken, n0);
  endtask

  // Station 80H holds the right at start and hands it to 81H when done.
  task automatic t_start_pass;
    do_reset(8'h80, 1'b1, '0, 1'b0);
    repeat (8) @(negedge sys_clk);
    check("holds_at_start", holds_right, 1'b1);
    work_done = 1'b1;
    @(negedge sys_clk);
    work_done = 1'b0;
    wait_tx(20);
    check("pass_msg", got, {8'h81, 8'h80, CMD_PASS});
    quiet(60);
    check("released", holds_right, 1'b0);
  endtask

  // With 81H mute, an idle 80H moves on to 82H after the reply wait.
  task automatic t_retry;
    do_reset(8'h80, 1'b0, 32'h0000_0002, 1'b0);
    wait_tx(30);
    check("first_try", got, {8'h81, 8'h80, CMD_PASS});
    wait_tx(REPLY_TIME_MS * MSC + 30);
    check("second_try", got, {8'h82, 8'h80, CMD_PASS});
    quiet(40);
  endtask

  // Station 85H ignores a transfer for 86H and answers one for itself, under stalls.
  task automatic t_receive;
    do_reset(8'h85, 1'b1, '0, 1'b1);
    repeat (8) @(negedge sys_clk);
    check("idle_at_start", holds_right, 1'b0);
    peer.send({8'h86, 8'h84, CMD_PASS});
    quiet(30);
    peer.send({8'h85, 8'h84, CMD_PASS});
    wait_tx(20);
    check("reply_msg", got, {8'h84, 8'h85, CMD_REPLY});
    repeat (3) @(negedge sys_clk);
    check("holds_after_reply", holds_right, 1'b1);
  endtask

  // Station 81H takes over from a silent 80H, then overruns its own tenure.
  task automatic t_takeover;
    int c0;
    do_reset(8'h81, 1'b1, '0, 1'b0);
    c0 = clears;
    wait_tx(MAX_TIME_MS * MSC + 60);
    check("takeover_msg", got, {STN_BCAST, 8'h81, CMD_TAKEOVER});
    repeat (3) @(negedge sys_clk);
    check("holds_after_takeover", holds_right, 1'b1);
    wait_tx(MAX_TIME_MS * MSC + 60);
    check("late_pass", got, {8'h82, 8'h81, CMD_PASS});
    check("clear_count", clears - c0, 1);
    check("clear_time", $unsigned(clear_at - hold_at - (MAX_TIME_MS - GUARD_MS) * MSC + 8) <= 16, 1'b1);
    quiet(40);
  endtask

  // Station 82H waits out the tenure of 80H and of 81H before its own takeover.
  task automatic t_second_takeover;
    do_reset(8'h82, 1'b1, '0, 1'b0);
    quiet(MAX_TIME_MS * MSC + 20);
    wait_tx(MAX_TIME_MS * MSC + 60);
    check("second_takeover", got, {STN_BCAST, 8'h82, CMD_TAKEOVER});
    check("module_nak", peer.faulty, 0);
  endtask

  // Main sequence.
  initial
  begin
    t_start_pass;
    t_retry;
    t_receive;
    t_takeover;
    t_second_takeover;
    end_of_test;
  end

  // The scenarios need about 2000 cycles; the limit allows five times that.
  initial
  begin
    #400_000;
    fails++;
    end_of_test;
  end
endmodule
